// *** hdl/window_watchdog.v ***
// window watchdog with apb register access, low-power mode handling and
// a stretched open-drain reset pin drive
// assumes the system reset logic answers wdog_reset_req_o by pulling rstn_i,
// and that cpu mode strobes are synchronous to clk_i
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "window_watchdog_map.vh"

// Function
// RULE_01: decrement counter every 16384 osc ticks
// RULE_02: reset on 40h to 3Fh while active
// RULE_03: reset when reloaded above window value
// RULE_04: software reloads only inside the window
// RULE_05: software writes values between FFh and C0h
// RULE_06: software option: off after reset, set-only enable
// RULE_07: hardware option: always active, enable bit ignored
// RULE_08: counter runs even when not activated
// RULE_09: enable with msb clear forces reset
// RULE_10: first decrement within bounded prescaler phase
// RULE_11: prescaler constants follow timebase_select
// RULE_12: halt with reset option gives reset
// RULE_13: halt: one decrement, then stop, no reset
// RULE_14: wake from halt resumes after delay
// RULE_15: reset ends halt into disabled state
// RULE_16: active-halt freezes counter, resumes on wake
// RULE_17: slow and wait modes keep normal rate
// RULE_18: software refreshes counter before halt
// RULE_19: both registers reset to 7Fh
// RULE_20: control holds activate bit and counter
// RULE_21: window check unsigned at each write
// RULE_22: single combined reset request pulse
module window_watchdog (
  input wire clk_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire osc_tick_i,
  input wire [1:0] timebase_select_i,
  input wire rtc_irq_enable_i,
  input wire hw_watchdog_option_i,
  input wire halt_reset_option_i,
  input wire halt_exec_i,
  input wire ext_irq_i,
  input wire osc_irq_i,
  input wire wake_delay_long_i,
  input wire wake_from_halt_i,
  output reg wdog_reset_req_o,
  output reg reset_pin_o,
  output reg reset_pin_oe_o,
  output reg wdog_active_o,
  output reg counting_o
);

  // low-power states of the counter
  localparam [2:0] ST_RUN = 3'd0; // normal, slow and wait operation
  localparam [2:0] ST_HALT_DEC = 3'd1; // halt entered, one decrement pending
  localparam [2:0] ST_HALTED = 3'd2; // halt, counter stopped
  localparam [2:0] ST_AHALT = 3'd3; // active-halt, counter frozen
  localparam [2:0] ST_WAKE = 3'd4; // waiting out the wake-up delay

  // register selection codes
  localparam [1:0] SEL_NONE = 2'd0;
  localparam [1:0] SEL_CTRL = 2'd1;
  localparam [1:0] SEL_WIN = 2'd2;

  // timing counts as plain integers, then cut to their counter widths
  localparam integer PIN_CYC_INT = `WDG_RST_PULSE_CYC;
  localparam integer WAKE_SHORT_INT = `WDG_WAKE_SHORT_CYC - 1;
  localparam integer WAKE_LONG_INT = `WDG_WAKE_LONG_CYC - 1;
  localparam [8:0] PIN_CYC = PIN_CYC_INT[8:0]; // reset pin low time
  localparam [12:0] WAKE_SHORT = WAKE_SHORT_INT[12:0]; // short wake-up delay less one
  localparam [12:0] WAKE_LONG = WAKE_LONG_INT[12:0]; // long wake-up delay less one
  localparam [7:0] CTRL_RST = `WDG_CTRL_RESET;
  localparam [7:0] WIN_RST = `WDG_WIN_RESET;

  // address decode shared by read capture and write strobes
  function [1:0] reg_sel;
    input [11:0] addr;
    begin
      if (addr == `WDG_CTRL_ADDR) begin
        reg_sel = SEL_CTRL;
      end else if (addr == `WDG_WIN_ADDR) begin
        reg_sel = SEL_WIN;
      end else begin
        reg_sel = SEL_NONE;
      end
    end
  endfunction

  // stored state and next-state values
  reg activate_ff; // software activation, set only
  reg [6:0] count_ff; // the 7-bit downcounter
  reg [6:0] window_ff; // window upper limit
  reg [2:0] state_ff; // low-power state
  reg [12:0] wake_cnt_ff; // wake-up delay counter
  reg boot_ff; // high in the first cycle after reset release
  reg [8:0] pin_cnt_ff; // reset pin low time left
  reg [2:0] nxt_state; // next low-power state
  reg [12:0] nxt_wake_cnt; // next wake-up delay count

  // decode and reset source nets
  wire dec_w; // decrement strobe from the prescaler
  wire active_w; // watchdog may raise a reset
  wire [1:0] sel_w; // decoded register
  wire access_w; // access phase before pready
  wire done_w; // access phase ending at this edge
  wire wr_ctrl_w; // control write takes effect
  wire wr_win_w; // window write takes effect
  wire run_w; // prescaler and counter may advance
  wire roll_rst_w; // rollover source
  wire early_rst_w; // reload above the window source
  wire forced_rst_w; // software forced source
  wire halt_rst_w; // reset on halt source
  wire any_rst_w; // combined request
  wire halt_enter_w; // halt without a reset

  // activation: hardware option or the set-only bit
  assign active_w = hw_watchdog_option_i | activate_ff; // RULE_06 RULE_07

  // apb phase decode, two-cycle access phase
  assign sel_w = reg_sel(paddr_i);
  assign access_w = psel_i & penable_i & ~pready_o;
  assign done_w = psel_i & penable_i & pready_o;
  assign wr_ctrl_w = done_w & pwrite_i & (sel_w == SEL_CTRL);
  assign wr_win_w = done_w & pwrite_i & (sel_w == SEL_WIN);

  // counting runs in normal, slow and wait modes and before the halt decrement
  assign run_w = (state_ff == ST_RUN) | (state_ff == ST_HALT_DEC); // RULE_08 RULE_17

  // rollover from 40h to 3Fh while active and running
  assign roll_rst_w = dec_w & ~wr_ctrl_w & (count_ff == `WDG_ROLL_VALUE) &
                      active_w & (state_ff == ST_RUN); // RULE_02

  // reload above the window, unsigned compare at the write
  assign early_rst_w = wr_ctrl_w & active_w & (count_ff > window_ff); // RULE_03 RULE_21

  // enabling write with the counter msb clear
  assign forced_rst_w = wr_ctrl_w & (active_w | pwdata_i[`WDG_ACT_BIT]) &
                        ~pwdata_i[`WDG_MSB_BIT]; // RULE_09

  // halt instruction with the reset-on-halt option
  assign halt_rst_w = halt_exec_i & active_w & halt_reset_option_i &
                      (state_ff == ST_RUN); // RULE_12

  // every source goes onto the one request, blocked while the pin is low
  // masking keeps a second source inside the same reset cycle from
  // restarting the pin stretch
  assign any_rst_w = (roll_rst_w | early_rst_w | forced_rst_w | halt_rst_w) &
                     ~reset_pin_oe_o; // RULE_22

  // halt entry without a reset
  // a halt that raises a reset never enters a low-power state
  assign halt_enter_w = halt_exec_i & ~halt_rst_w & (state_ff == ST_RUN);

  // prescaler shared with the clock controller time base
  wdog_prescaler u_presc (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .osc_tick_i(osc_tick_i),
    .run_i(run_w),
    .load_i(wr_ctrl_w),
    .timebase_select_i(timebase_select_i),
    .dec_o(dec_w)
  );

  // apb slave: pready one cycle into the access phase, data captured with it
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= access_w;
      if (access_w) begin
        // unmapped addresses answer with an error and zero data
        pslverr_o <= (sel_w == SEL_NONE);
        case (sel_w)
          SEL_CTRL: begin
            prdata_o <= {24'h000000, activate_ff, count_ff}; // RULE_20
          end
          SEL_WIN: begin
            prdata_o <= {25'h0000000, window_ff};
          end
          default: begin
            prdata_o <= 32'h00000000;
          end
        endcase
      end else begin
        // outside the answer cycle the read bus rests at zero
        pslverr_o <= 1'b0;
        prdata_o <= 32'h00000000;
      end
    end
  end

  // activation bit, set by software, cleared only by reset
  // with the hardware option the bit still stores but is not needed
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      activate_ff <= CTRL_RST[`WDG_ACT_BIT]; // RULE_19 RULE_15
    end else if (wr_ctrl_w && pwdata_i[`WDG_ACT_BIT]) begin
      activate_ff <= 1'b1; // RULE_06 RULE_20
    end
  end

  // downcounter: a reload wins over a decrement in the same cycle
  // the prescaler takes its new phase on the same reload once its stage has reached first_w
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      count_ff <= CTRL_RST[6:0]; // RULE_19
    end else if (wr_ctrl_w) begin
      count_ff <= pwdata_i[6:0]; // RULE_20
    end else if (dec_w) begin
      count_ff <= count_ff - 7'h01; // RULE_01 RULE_08 RULE_13
    end
  end

  // window register
  // bit 7 of the window word is reserved and dropped
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      window_ff <= WIN_RST[6:0]; // RULE_19
    end else if (wr_win_w) begin
      window_ff <= pwdata_i[6:0];
    end
  end

  // first cycle after reset release, used to catch the halt wake strap
  // wake_from_halt_i only matters in that one cycle
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      boot_ff <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
    end
  end

  // low-power state machine
  always @* begin
    nxt_state = state_ff;
    nxt_wake_cnt = wake_cnt_ff;
    case (state_ff)
      ST_RUN: begin
        if (boot_ff && wake_from_halt_i) begin
          // reset ended a halt: wait before counting again
          nxt_state = ST_WAKE; // RULE_14 RULE_15
          nxt_wake_cnt = wake_delay_long_i ? WAKE_LONG : WAKE_SHORT;
        end else if (halt_enter_w && rtc_irq_enable_i) begin
          // active-halt: counter frozen at once
          nxt_state = ST_AHALT; // RULE_16
        end else if (halt_enter_w) begin
          // plain halt: let one decrement through
          nxt_state = ST_HALT_DEC; // RULE_13
        end
      end
      ST_HALT_DEC: begin
        // one more decrement, then the counter stops
        // no rollover reset is raised outside the run state
        if (dec_w) begin
          nxt_state = ST_HALTED; // RULE_13
        end
      end
      ST_HALTED: begin
        // an external interrupt wakes the cpu, counting waits for the delay
        if (ext_irq_i) begin
          nxt_state = ST_WAKE; // RULE_14
          nxt_wake_cnt = wake_delay_long_i ? WAKE_LONG : WAKE_SHORT;
        end
      end
      ST_AHALT: begin
        // oscillator or external interrupt resumes counting at once
        if (osc_irq_i || ext_irq_i) begin
          nxt_state = ST_RUN; // RULE_16
        end
      end
      ST_WAKE: begin
        // count the wake-up delay down to zero
        if (wake_cnt_ff == 13'h0000) begin
          nxt_state = ST_RUN; // RULE_14
        end else begin
          nxt_wake_cnt = wake_cnt_ff - 13'h0001;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // state and wake counter registers
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      state_ff <= ST_RUN;
      wake_cnt_ff <= 13'h0000;
    end else begin
      state_ff <= nxt_state;
      wake_cnt_ff <= nxt_wake_cnt;
    end
  end

  // reset request pulse and stretched open-drain pin drive
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      wdog_reset_req_o <= 1'b0;
      reset_pin_o <= 1'b0;
      reset_pin_oe_o <= 1'b0;
      pin_cnt_ff <= 9'h000;
    end else begin
      wdog_reset_req_o <= any_rst_w; // RULE_22
      reset_pin_o <= 1'b0;
      if (any_rst_w) begin
        // pin pulled low for PIN_CYC cycles from the reset cycle
        reset_pin_oe_o <= 1'b1; // RULE_02
        pin_cnt_ff <= PIN_CYC - 9'h001;
      end else if (pin_cnt_ff != 9'h000) begin
        // hold the pull while time is left
        pin_cnt_ff <= pin_cnt_ff - 9'h001;
      end else begin
        // release the pin
        reset_pin_oe_o <= 1'b0;
      end
    end
  end

  // status outputs
  // both follow their sources one cycle late
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      wdog_active_o <= 1'b0;
      counting_o <= 1'b0;
    end else begin
      wdog_active_o <= active_w;
      counting_o <= run_w;
    end
  end

endmodule

// *** hdl/window_watchdog_map.vh ***
// register map, reset values and timing counts of the window watchdog
// assumes a 10 MHz system clock and an external osc_div_clock tick strobe
`ifndef WINDOW_WATCHDOG_MAP_VH
`define WINDOW_WATCHDOG_MAP_VH

// register indices as printed, byte address is four times the index
`define WDG_CTRL_INDEX 8'h2a
`define WDG_WIN_INDEX 8'h30
`define WDG_CTRL_ADDR 12'h0a8
`define WDG_WIN_ADDR 12'h0c0

// field positions of the control register
`define WDG_ACT_BIT 7
`define WDG_MSB_BIT 6

// reset values
`define WDG_CTRL_RESET 8'h7f
`define WDG_WIN_RESET 8'h7f

// counter value whose decrement raises the reset
`define WDG_ROLL_VALUE 7'h40

// clock and reset pin timing
`define WDG_CLK_PERIOD_NS 100
`define WDG_RST_PULSE_NS 30000
`define WDG_RST_PULSE_CYC ((`WDG_RST_PULSE_NS + `WDG_CLK_PERIOD_NS - 1) / `WDG_CLK_PERIOD_NS)

// wake-up delays in cpu clocks
`define WDG_WAKE_SHORT_CYC 256
`define WDG_WAKE_LONG_CYC 4096

// prescaler: 64 ticks per unit, 256 units per decrement (16384 ticks)
`define WDG_PRESC_PERIOD 16384
`define WDG_UNIT_TICKS 64
`define WDG_FIRST_BASE 8'h80
`define WDG_SHORT_BASE 8'hc0

// time base constants per timebase_select
`define WDG_TB0_MSB 8'h04
`define WDG_TB0_LSB 8'h3b
`define WDG_TB1_MSB 8'h08
`define WDG_TB1_LSB 8'h35
`define WDG_TB2_MSB 8'h14
`define WDG_TB2_LSB 8'h23
`define WDG_TB3_MSB 8'h31
`define WDG_TB3_LSB 8'h36

`endif

// *** hdl/wdog_prescaler.v ***
// prescaler that produces the watchdog decrement strobe from osc ticks
// assumes osc_tick_i is a one-cycle strobe per osc_div_clock period
`timescale 1ns/1ps
`include "window_watchdog_map.vh"

module wdog_prescaler (
  input wire clk_i,
  input wire rstn_i,
  input wire osc_tick_i,
  input wire run_i,
  input wire load_i,
  input wire [1:0] timebase_select_i,
  output reg dec_o
);

  // time base msb constant for a selection
  function [7:0] tb_msb;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: tb_msb = `WDG_TB0_MSB;
        2'b01: tb_msb = `WDG_TB1_MSB;
        2'b10: tb_msb = `WDG_TB2_MSB;
        default: tb_msb = `WDG_TB3_MSB;
      endcase
    end
  endfunction

  // time base lsb constant for a selection
  function [7:0] tb_lsb;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: tb_lsb = `WDG_TB0_LSB;
        2'b01: tb_lsb = `WDG_TB1_LSB;
        2'b10: tb_lsb = `WDG_TB2_LSB;
        default: tb_lsb = `WDG_TB3_LSB;
      endcase
    end
  endfunction

  reg [5:0] unit_ff; // ticks inside one 64-tick unit
  reg [7:0] stage_ff; // units inside one decrement period
  reg [7:0] acc_ff; // phase accumulator of the shared time base
  wire [7:0] msb_w = tb_msb(timebase_select_i);
  wire [7:0] lsb_w = tb_lsb(timebase_select_i);
  wire [7:0] acc_add_w = acc_ff + 8'd4;
  wire [7:0] first_w = `WDG_FIRST_BASE - lsb_w; // start unit giving (lsb+128) units
  wire [7:0] short_w = `WDG_SHORT_BASE + lsb_w; // units of a shortened period
  wire [7:0] short_start_w = 8'd0 - short_w; // start unit giving (lsb+192) units

  // unit counter, stage counter and strobe
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      unit_ff <= 6'h00;
      stage_ff <= 8'h00;
      acc_ff <= 8'h00;
      dec_o <= 1'b0;
    end else begin
      dec_o <= 1'b0;
      if (load_i && (stage_ff >= first_w)) begin
        // a reload never sees less than the minimum first period
        unit_ff <= 6'h00; // RULE_10
        stage_ff <= first_w; // RULE_10
      end else if (osc_tick_i && run_i) begin
        unit_ff <= unit_ff + 6'h01;
        if (unit_ff == 6'h3f) begin
          if (stage_ff == 8'hff) begin
            dec_o <= 1'b1; // RULE_01
            // time base end shortens the next period
            if (acc_add_w >= msb_w) begin
              acc_ff <= acc_add_w - msb_w; // RULE_11
              stage_ff <= short_start_w; // RULE_11
            end else begin
              acc_ff <= acc_add_w;
              stage_ff <= 8'h00;
            end
          end else begin
            stage_ff <= stage_ff + 8'h01;
          end
        end
      end
    end
  end

endmodule

// *** verification/window_watchdog_monitor.sv ***
// checker of the watchdog reset request, reset pin pull and bus answers
// assumes a bind onto window_watchdog and its single clock domain
`timescale 1ns/1ps
`include "window_watchdog_map.vh"
module window_watchdog_monitor (
  input wire clk_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire hw_watchdog_option_i,
  input wire halt_reset_option_i,
  input wire halt_exec_i,
  input wire wdog_reset_req_o,
  input wire reset_pin_oe_o,
  input wire wdog_active_o,
  input wire counting_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  reg [8:0] pull_ff; // cycles of the current pin pull
  // count how long the pin has been pulled
  always @(posedge clk_i) begin
    if (!rstn_i || !reset_pin_oe_o) begin
      pull_ff <= 9'h000;
    end else begin
      pull_ff <= pull_ff + 9'h001;
    end
  end
  // completed control write that activates with the msb clear
  wire force_wr = psel_i & penable_i & pready_o & pwrite_i & pwdata_i[7] & ~pwdata_i[6]
    & (paddr_i == `WDG_CTRL_ADDR);
  property p_req_pulse; wdog_reset_req_o |=> !wdog_reset_req_o; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request too long");
  property p_req_pin; wdog_reset_req_o |-> reset_pin_oe_o && !$past(reset_pin_oe_o); endproperty
  a_req_pin: assert property (p_req_pin) else $error("pin not pulled with request");
  property p_pin_rise; $rose(reset_pin_oe_o) |-> wdog_reset_req_o; endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("pin pulled alone");
  // 300 cycles of pull
  property p_pin_len; $past(rstn_i) && $fell(reset_pin_oe_o) |-> pull_ff == 9'h12c; endproperty
  a_pin_len: assert property (p_pin_len) else $error("pin pull length wrong");
  property p_mask; $past(reset_pin_oe_o) |-> !wdog_reset_req_o; endproperty
  a_mask: assert property (p_mask) else $error("request while pin pulled");
  property p_ready; pready_o |-> $past(psel_i && penable_i) ##1 !pready_o; endproperty
  a_ready: assert property (p_ready) else $error("bad ready");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_hw; $past(hw_watchdog_option_i) && $past(rstn_i) |-> wdog_active_o; endproperty
  a_hw: assert property (p_hw) else $error("hardware option not active");
  property p_sticky; $past(wdog_active_o) && $past(rstn_i)
    && !$past(hw_watchdog_option_i, 2) |-> wdog_active_o; endproperty
  a_sticky: assert property (p_sticky) else $error("activation lost");
  property p_force; force_wr && !reset_pin_oe_o |=> wdog_reset_req_o; endproperty
  a_force: assert property (p_force) else $error("no forced reset");
  property p_halt; halt_exec_i && halt_reset_option_i && wdog_active_o && counting_o
    && !reset_pin_oe_o |=> wdog_reset_req_o; endproperty
  a_halt: assert property (p_halt) else $error("no reset on halt");
  c_force: cover property (force_wr ##1 wdog_reset_req_o);
  c_halt: cover property (halt_exec_i ##1 wdog_reset_req_o);
  c_pull: cover property ($fell(reset_pin_oe_o));
endmodule
bind window_watchdog window_watchdog_monitor u_mon (.clk_i, .rstn_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .hw_watchdog_option_i,
  .halt_reset_option_i, .halt_exec_i, .wdog_reset_req_o, .reset_pin_oe_o, .wdog_active_o,
  .counting_o);

// *** verification/window_watchdog_tb_top.sv ***
// self-checking bench of the window watchdog driven over apb
// assumes the bound monitor and the hdl/ include path
`timescale 1ns/1ps
`include "window_watchdog_map.vh"
module window_watchdog_tb_top;
  localparam logic [11:0] ctrl_a = `WDG_CTRL_ADDR; // control word
  localparam logic [11:0] win_a = `WDG_WIN_ADDR; // window word
  logic clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [1:0] timebase_select_i = 2'h0;
  logic osc_tick_i = 1'b1, rtc_irq_enable_i = 1'b0, hw_watchdog_option_i = 1'b0;
  logic halt_reset_option_i = 1'b0, halt_exec_i = 1'b0, ext_irq_i = 1'b0, osc_irq_i = 1'b0;
  logic wake_delay_long_i = 1'b0, wake_from_halt_i = 1'b0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, wdog_reset_req_o, reset_pin_o, reset_pin_oe_o, wdog_active_o;
  wire counting_o;
  logic [31:0] rd_v; // last read data
  logic er_v; // last error answer
  integer error_cnt = 0, n_checks = 0, cyc = 0, req_cnt = 0, t = 0, r0 = 0, k = 0;
  window_watchdog dut (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .osc_tick_i, .timebase_select_i, .rtc_irq_enable_i,
    .hw_watchdog_option_i, .halt_reset_option_i, .halt_exec_i, .ext_irq_i, .osc_irq_i,
    .wake_delay_long_i, .wake_from_halt_i, .wdog_reset_req_o, .reset_pin_o, .reset_pin_oe_o,
    .wdog_active_o, .counting_o);
  // 10 MHz clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // cycle count, request count and hang limit
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (wdog_reset_req_o === 1'b1) req_cnt <= req_cnt + 1;
    if (cyc == 95000) begin
      $display("CHECK FAILED at %0t: timeout", $time);
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // reset held 20 cycles with the given option and wake flag
  task do_reset(input logic hw, input logic wk);
    rstn_i <= 1'b0;
    hw_watchdog_option_i <= hw;
    wake_from_halt_i <= wk;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
  endtask
  // one apb transfer, then one idle cycle
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    integer n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n = n + 1;
    end while (pready_o !== 1'b1 && n < 20);
    rd_v = prdata_o;
    er_v = pslverr_o;
    chk(pready_o, 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // wait for a reset request, at most lim cycles
  task wait_req(input integer lim);
    t = 0;
    while (wdog_reset_req_o !== 1'b1 && t < lim) begin
      @(posedge clk_i);
      t = t + 1;
    end
  endtask
  task pulse_halt;
    halt_exec_i <= 1'b1;
    @(posedge clk_i);
    halt_exec_i <= 1'b0;
  endtask
  task t_regs;
    do_reset(1'b0, 1'b0);
    apb(1'b0, ctrl_a, 8'h00);
    chk(rd_v, 32'h7f);
    apb(1'b0, win_a, 8'h00);
    chk(rd_v, 32'h7f);
    apb(1'b1, win_a, 8'hd5); // reserved bit written high
    apb(1'b0, win_a, 8'h00);
    chk(rd_v, 32'h55);
    apb(1'b0, 12'h0a4, 8'h00); // unmapped word
    chk(er_v, 1'b1);
    chk(wdog_active_o, 1'b0);
    $display("t_regs done");
  endtask
  task t_window;
    do_reset(1'b0, 1'b0);
    r0 = req_cnt;
    apb(1'b1, ctrl_a, 8'hff); // count equal to window
    apb(1'b1, ctrl_a, 8'h7f); // clearing activate has no effect
    apb(1'b1, ctrl_a, 8'hfe);
    apb(1'b1, ctrl_a, 8'hff); // reload below the window
    apb(1'b0, ctrl_a, 8'h00);
    chk(rd_v, 32'hff);
    chk(req_cnt - r0, 0);
    chk(wdog_active_o, 1'b1);
    apb(1'b1, win_a, 8'h50);
    apb(1'b1, ctrl_a, 8'hff); // reload above the window
    wait_req(4);
    chk(t < 4, 1'b1);
    apb(1'b1, ctrl_a, 8'hbf); // forced while the pin is pulled
    repeat (310) @(posedge clk_i);
    chk(req_cnt - r0, 1);
    chk(reset_pin_oe_o, 1'b0);
    $display("t_window done");
  endtask
  task t_forced(input logic hw);
    do_reset(hw, 1'b0);
    r0 = req_cnt;
    apb(1'b1, ctrl_a, 8'h3f); // msb and activate clear
    repeat (4) @(posedge clk_i);
    chk(req_cnt - r0, hw);
    chk(wdog_active_o, hw);
    if (!hw) begin
      apb(1'b1, ctrl_a, 8'hbf);
      wait_req(4);
      chk(t < 4, 1'b1);
    end
    $display("t_forced done");
  endtask
  task t_halt;
    do_reset(1'b0, 1'b0);
    apb(1'b1, ctrl_a, 8'hff);
    halt_reset_option_i <= 1'b1;
    @(posedge clk_i);
    pulse_halt;
    wait_req(4);
    chk(t < 4, 1'b1);
    halt_reset_option_i <= 1'b0;
    $display("t_halt done");
  endtask
  // active-halt woken by the oscillator, then by an external interrupt
  task t_ahalt;
    integer j;
    do_reset(1'b0, 1'b0);
    apb(1'b1, ctrl_a, 8'hff);
    rtc_irq_enable_i <= 1'b1;
    r0 = req_cnt;
    for (j = 0; j < 2; j++) begin
      pulse_halt;
      repeat (3) @(posedge clk_i);
      chk(counting_o, 1'b0);
      osc_irq_i <= (j == 0);
      ext_irq_i <= (j == 1);
      @(posedge clk_i);
      osc_irq_i <= 1'b0;
      ext_irq_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(counting_o, 1'b1);
    end
    chk(req_cnt - r0, 0);
    rtc_irq_enable_i <= 1'b0;
    $display("t_ahalt done");
  endtask
  // reset that ends halt: 256 cycle restart, disabled
  task t_wake;
    do_reset(1'b0, 1'b1);
    wake_from_halt_i <= 1'b0;
    repeat (200) @(posedge clk_i);
    chk(counting_o, 1'b0);
    repeat (70) @(posedge clk_i);
    chk(counting_o, 1'b1);
    chk(wdog_active_o, 1'b0);
    $display("t_wake done");
  endtask
  // halt without the reset option: one decrement, stop, long wake-up
  task t_sleep;
    do_reset(1'b0, 1'b0);
    wake_delay_long_i <= 1'b1;
    apb(1'b1, ctrl_a, 8'h7f);
    pulse_halt;
    t = 0;
    while (counting_o !== 1'b0 && t < 17000) begin
      @(posedge clk_i);
      t = t + 1;
    end
    chk(t > 16000 && t < 17000, 1'b1);
    apb(1'b0, ctrl_a, 8'h00);
    chk(rd_v, 32'h7e);
    ext_irq_i <= 1'b1;
    @(posedge clk_i);
    ext_irq_i <= 1'b0;
    repeat (4000) @(posedge clk_i);
    chk(counting_o, 1'b0);
    repeat (100) @(posedge clk_i);
    chk(counting_o, 1'b1);
    wake_delay_long_i <= 1'b0;
    $display("t_sleep done");
  endtask
  // load count 41h, two decrements reach 3Fh
  task t_run(input logic [1:0] tb, input logic [7:0] d);
    timebase_select_i <= tb;
    do_reset(1'b0, 1'b0);
    r0 = req_cnt;
    apb(1'b1, ctrl_a, d);
    wait_req(33000);
    apb(1'b0, ctrl_a, 8'h00);
    chk(rd_v, {24'h0, d[7], 7'h3f});
    chk(req_cnt - r0, d[7]);
    if (d[7]) chk(t >= 28030 && t <= 32772, 1'b1);
    $display("t_run done");
  endtask
  initial begin
    t_regs;
    t_window;
    for (k = 0; k < 2; k++) t_forced(k[0]);
    t_halt;
    t_ahalt;
    t_wake;
    t_sleep;
    t_run(2'h0, 8'h41);
    t_run(2'h3, 8'hc1);
    report_and_stop;
  end
endmodule
